// ### rtl/iopm_cfg.svh
// Register map, field positions and reset values of the I/O port block.
// Included by the top module; definitions only.
`ifndef IOPM_CFG_SVH
`define IOPM_CFG_SVH

`define IOPM_ADDR_W          8
`define IOPM_DATA_W          32
`define IOPM_PORT_W          8
`define IOPM_MODE_W          16

`define IOPM_OFS_P1_OUT      8'h00
`define IOPM_OFS_P1_MODE     8'h04
`define IOPM_OFS_P3_OUT      8'h08
`define IOPM_OFS_P3_MODE     8'h0c
`define IOPM_OFS_P1_PIN      8'h10
`define IOPM_OFS_P3_PIN      8'h14
`define IOPM_OFS_IRQ_EN      8'h18
`define IOPM_OFS_ALT_CTL     8'h1c

`define IOPM_RST_OUT         8'hff
`define IOPM_RST_MODE        16'h0000
`define IOPM_RST_IRQ_EN      8'h00
`define IOPM_RST_ALT_CTL     3'h0

`define IOPM_ALT_W           3
`define IOPM_ALT_SPI_EN      0
`define IOPM_ALT_SPI_MASTER  1
`define IOPM_ALT_T0_PWM      2

`define IOPM_BIT_RST         3
`define IOPM_BIT_SS          4
`define IOPM_BIT_MOSI        5
`define IOPM_BIT_MISO        6
`define IOPM_BIT_SCK         7
`define IOPM_BIT_T0          4

`endif

// ### rtl/iopm_pkg.sv
// Types shared by the I/O port block modules.
// Constants live in iopm_cfg.svh.
package iopm_pkg;

    typedef enum logic [1:0]
    {
        IOPM_QUASI  = 2'b00,
        IOPM_PUSH   = 2'b01,
        IOPM_INPUT  = 2'b10,
        IOPM_OPEN   = 2'b11
    } iopm_mode_type;

endpackage

// ### rtl/iopm_sync.sv
// Two-flop synchroniser for a vector of pad levels.
// Assumes the inputs are asynchronous to pclk.
`timescale 1ns/1ps

module iopm_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_ff
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = async_in;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_ff <= '1;
            sync_ff <= '1;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

endmodule

// ### rtl/iopm_pad.sv
// Output stage of one port pin for the four drive modes.
// Assumes the pad cell combines strong drive, enable and weak pull-up.
`timescale 1ns/1ps

module iopm_pad
    import iopm_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    input  iopm_mode_type mode,
    input  wire logic    dout,
    input  wire logic    force_in,
    output logic         pad_do_ff,
    output logic         pad_oe_ff,
    output logic         pad_wpu_ff
);

    iopm_mode_type eff_mode;
    logic          prev_ff;
    logic          nxt_prev;
    logic          nxt_do;
    logic          nxt_oe;
    logic          nxt_wpu;

    always_comb
    begin
        eff_mode = force_in ? IOPM_INPUT : mode;
        nxt_prev = dout;
        nxt_do   = 1'b0;
        nxt_oe   = 1'b0;
        nxt_wpu  = 1'b0;
        unique case (eff_mode)
            IOPM_QUASI:
            begin
                // Strong low, weak high, one-cycle strong boost on rising
                nxt_do  = dout;
                nxt_oe  = !dout || !prev_ff; // R05
                nxt_wpu = dout; // R05
            end
            IOPM_PUSH:
            begin
                nxt_do = dout; // R03
                nxt_oe = 1'b1; // R03
            end
            IOPM_INPUT:
            begin
                nxt_oe = 1'b0; // R02
            end
            IOPM_OPEN:
            begin
                nxt_do = 1'b0; // R04
                nxt_oe = !dout; // R04
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_ff    <= 1'b1;
            pad_do_ff  <= 1'b0;
            pad_oe_ff  <= 1'b0;
            pad_wpu_ff <= 1'b0;
        end
        else
        begin
            prev_ff    <= nxt_prev;
            pad_do_ff  <= nxt_do;
            pad_oe_ff  <= nxt_oe;
            pad_wpu_ff <= nxt_wpu;
        end
    end

endmodule

// ### rtl/iopm_top.sv
// Port 1 and port 3 pad logic with drive modes and pin multiplexing.
// Assumes an APB master on pclk; fuse and debug enables come from pclk logic.
// Summary of operation
// R01: every pin has its own two-bit mode, chosen independently.
// R02: input mode switches off both drivers; pad floats.
// R03: push-pull mode drives pad high and low from the output value.
// R04: open-drain mode pulls low on zero, releases pad on one.
// R05: quasi mode gives weak pull-up and strong pull-down.
// R06: all eight port 1 pins can be enabled as interrupt sources.
// R07: port 1 bit n feeds general-purpose interrupt input n.
// R08: master-out line is output as master, input as slave.
// R09: serial clock line is output as master, input as slave.
// R10: port 1 bit 3 is active-low reset input when reset fuse set.
// R11: port 1 bit 3 carries debug serial clock when debug enabled.
// R12: port 3 bit 4 is timer 0 count input or its PWM output.
// R13: master-in line is input as master, output as slave.
// R14: port 1 bit 4 supplies the serial slave-select input.
// R15: alternate outputs reach the pad through the pin's mode stage.
`timescale 1ns/1ps
`include "iopm_cfg.svh"

module iopm_top
    import iopm_pkg::*;
(
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`IOPM_ADDR_W-1:0]  paddr,
    input  wire logic [`IOPM_DATA_W-1:0]  pwdata,
    output logic      [`IOPM_DATA_W-1:0]  prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [`IOPM_PORT_W-1:0]  port1_pin_in,
    output logic      [`IOPM_PORT_W-1:0]  port1_pad_out,
    output logic      [`IOPM_PORT_W-1:0]  port1_pad_oe,
    output logic      [`IOPM_PORT_W-1:0]  port1_pad_pullup,
    input  wire logic [`IOPM_PORT_W-1:0]  port3_pin_in,
    output logic      [`IOPM_PORT_W-1:0]  port3_pad_out,
    output logic      [`IOPM_PORT_W-1:0]  port3_pad_oe,
    output logic      [`IOPM_PORT_W-1:0]  port3_pad_pullup,
    input  wire logic                     reset_fuse_enable,
    input  wire logic                     onchip_debug_enable,
    input  wire logic                     spi_mosi_out,
    input  wire logic                     spi_sck_out,
    input  wire logic                     spi_miso_out,
    input  wire logic                     timer0_pwm_out,
    output logic                          spi_mosi_in,
    output logic                          spi_sck_in,
    output logic                          spi_miso_in,
    output logic                          spi_ss_n,
    output logic                          ext_reset_n,
    output logic                          debug_serial_clock,
    output logic                          timer0_count_in,
    output logic      [`IOPM_PORT_W-1:0]  gp_irq_in
);

    // Register state
    logic [`IOPM_PORT_W-1:0] p1_out_ff;
    logic [`IOPM_MODE_W-1:0] p1_mode_ff;
    logic [`IOPM_PORT_W-1:0] p3_out_ff;
    logic [`IOPM_MODE_W-1:0] p3_mode_ff;
    logic [`IOPM_PORT_W-1:0] irq_en_ff;
    logic [`IOPM_ALT_W-1:0]  alt_ctl_ff;
    logic [`IOPM_DATA_W-1:0] prdata_ff;
    logic                    pready_ff;
    logic                    pslverr_ff;
    logic [`IOPM_PORT_W-1:0] nxt_p1_out;
    logic [`IOPM_MODE_W-1:0] nxt_p1_mode;
    logic [`IOPM_PORT_W-1:0] nxt_p3_out;
    logic [`IOPM_MODE_W-1:0] nxt_p3_mode;
    logic [`IOPM_PORT_W-1:0] nxt_irq_en;
    logic [`IOPM_ALT_W-1:0]  nxt_alt_ctl;
    logic [`IOPM_DATA_W-1:0] nxt_prdata;
    logic                    nxt_pready;
    logic                    nxt_pslverr;

    // Synchronised pad levels
    logic [`IOPM_PORT_W-1:0] p1_sync;
    logic [`IOPM_PORT_W-1:0] p3_sync;

    // Alternate-function inputs to the peripherals
    logic                    mosi_in_ff;
    logic                    sck_in_ff;
    logic                    miso_in_ff;
    logic                    ss_n_ff;
    logic                    ext_rst_n_ff;
    logic                    dbg_clk_ff;
    logic                    t0_in_ff;
    logic [`IOPM_PORT_W-1:0] gp_irq_ff;
    logic                    nxt_mosi_in;
    logic                    nxt_sck_in;
    logic                    nxt_miso_in;
    logic                    nxt_ss_n;
    logic                    nxt_ext_rst_n;
    logic                    nxt_dbg_clk;
    logic                    nxt_t0_in;
    logic [`IOPM_PORT_W-1:0] nxt_gp_irq;

    // Pad steering
    logic [`IOPM_PORT_W-1:0] p1_dout;
    logic [`IOPM_PORT_W-1:0] p1_force;
    logic [`IOPM_PORT_W-1:0] p3_dout;
    logic [`IOPM_PORT_W-1:0] p3_force;

    logic                    spi_en;
    logic                    spi_master;
    logic                    t0_pwm;
    logic                    setup_ph;
    logic                    wr_access;

    assign spi_en     = alt_ctl_ff[`IOPM_ALT_SPI_EN];
    assign spi_master = alt_ctl_ff[`IOPM_ALT_SPI_MASTER];
    assign t0_pwm     = alt_ctl_ff[`IOPM_ALT_T0_PWM];
    assign setup_ph   = psel && !penable;
    assign wr_access  = psel && penable && pready_ff && pwrite;

    iopm_sync #(
        .W(`IOPM_PORT_W)
    ) u_sync_p1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port1_pin_in),
        .sync_ff  (p1_sync)
    );

    iopm_sync #(
        .W(`IOPM_PORT_W)
    ) u_sync_p3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (port3_pin_in),
        .sync_ff  (p3_sync)
    );

    // APB slave: no wait state, answer registered in the setup cycle
    always_comb
    begin
        nxt_p1_out  = p1_out_ff;
        nxt_p1_mode = p1_mode_ff;
        nxt_p3_out  = p3_out_ff;
        nxt_p3_mode = p3_mode_ff;
        nxt_irq_en  = irq_en_ff;
        nxt_alt_ctl = alt_ctl_ff;
        nxt_prdata  = prdata_ff;
        nxt_pready  = 1'b0;
        nxt_pslverr = 1'b0;
        if (setup_ph)
        begin
            nxt_pready = 1'b1;
            nxt_prdata = '0;
            unique case (paddr)
                `IOPM_OFS_P1_OUT:  nxt_prdata[`IOPM_PORT_W-1:0] = p1_out_ff;
                `IOPM_OFS_P1_MODE: nxt_prdata[`IOPM_MODE_W-1:0] = p1_mode_ff;
                `IOPM_OFS_P3_OUT:  nxt_prdata[`IOPM_PORT_W-1:0] = p3_out_ff;
                `IOPM_OFS_P3_MODE: nxt_prdata[`IOPM_MODE_W-1:0] = p3_mode_ff;
                `IOPM_OFS_P1_PIN:  nxt_prdata[`IOPM_PORT_W-1:0] = p1_sync;
                `IOPM_OFS_P3_PIN:  nxt_prdata[`IOPM_PORT_W-1:0] = p3_sync;
                `IOPM_OFS_IRQ_EN:  nxt_prdata[`IOPM_PORT_W-1:0] = irq_en_ff;
                `IOPM_OFS_ALT_CTL: nxt_prdata[`IOPM_ALT_W-1:0]  = alt_ctl_ff;
                default:           nxt_pslverr = 1'b1;
            endcase
        end
        else if (psel && penable && !pready_ff)
        begin
            nxt_pready  = 1'b1;
            nxt_pslverr = pslverr_ff;
        end
        if (wr_access)
        begin
            unique case (paddr)
                `IOPM_OFS_P1_OUT:  nxt_p1_out  = pwdata[`IOPM_PORT_W-1:0];
                `IOPM_OFS_P1_MODE: nxt_p1_mode = pwdata[`IOPM_MODE_W-1:0]; // R01
                `IOPM_OFS_P3_OUT:  nxt_p3_out  = pwdata[`IOPM_PORT_W-1:0];
                `IOPM_OFS_P3_MODE: nxt_p3_mode = pwdata[`IOPM_MODE_W-1:0]; // R01
                `IOPM_OFS_IRQ_EN:  nxt_irq_en  = pwdata[`IOPM_PORT_W-1:0]; // R06
                `IOPM_OFS_ALT_CTL: nxt_alt_ctl = pwdata[`IOPM_ALT_W-1:0];
                default:           nxt_p1_out  = p1_out_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            p1_out_ff  <= `IOPM_RST_OUT;
            p1_mode_ff <= `IOPM_RST_MODE;
            p3_out_ff  <= `IOPM_RST_OUT;
            p3_mode_ff <= `IOPM_RST_MODE;
            irq_en_ff  <= `IOPM_RST_IRQ_EN;
            alt_ctl_ff <= `IOPM_RST_ALT_CTL;
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else
        begin
            p1_out_ff  <= nxt_p1_out;
            p1_mode_ff <= nxt_p1_mode;
            p3_out_ff  <= nxt_p3_out;
            p3_mode_ff <= nxt_p3_mode;
            irq_en_ff  <= nxt_irq_en;
            alt_ctl_ff <= nxt_alt_ctl;
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    // Pin multiplexing: which source drives each pad, which pads are inputs
    always_comb
    begin
        p1_dout  = p1_out_ff;
        p1_force = '0;
        p3_dout  = p3_out_ff;
        p3_force = '0;
        if (spi_en)
        begin
            if (spi_master)
            begin
                p1_dout[`IOPM_BIT_MOSI]  = spi_mosi_out; // R08 R15
                p1_dout[`IOPM_BIT_SCK]   = spi_sck_out; // R09 R15
                p1_force[`IOPM_BIT_MISO] = 1'b1; // R13
            end
            else
            begin
                p1_force[`IOPM_BIT_MOSI] = 1'b1; // R08
                p1_force[`IOPM_BIT_SCK]  = 1'b1; // R09
                p1_dout[`IOPM_BIT_MISO]  = spi_miso_out; // R13 R15
            end
            p1_force[`IOPM_BIT_SS] = 1'b1; // R14
        end
        if (reset_fuse_enable || onchip_debug_enable)
        begin
            p1_force[`IOPM_BIT_RST] = 1'b1; // R10 R11
        end
        if (t0_pwm)
        begin
            p3_dout[`IOPM_BIT_T0] = timer0_pwm_out; // R12 R15
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `IOPM_PORT_W; gi++)
        begin : g_pin
            iopm_pad u_pad_p1 (
                .pclk       (pclk),
                .presetn    (presetn),
                .mode       (iopm_mode_type'(p1_mode_ff[2*gi +: 2])), // R01
                .dout       (p1_dout[gi]),
                .force_in   (p1_force[gi]),
                .pad_do_ff  (port1_pad_out[gi]),
                .pad_oe_ff  (port1_pad_oe[gi]),
                .pad_wpu_ff (port1_pad_pullup[gi])
            );
            iopm_pad u_pad_p3 (
                .pclk       (pclk),
                .presetn    (presetn),
                .mode       (iopm_mode_type'(p3_mode_ff[2*gi +: 2])), // R01
                .dout       (p3_dout[gi]),
                .force_in   (p3_force[gi]),
                .pad_do_ff  (port3_pad_out[gi]),
                .pad_oe_ff  (port3_pad_oe[gi]),
                .pad_wpu_ff (port3_pad_pullup[gi])
            );
        end
    endgenerate

    // Inputs delivered to the peripherals; idle high when not selected, except debug clock and interrupts, which idle low, and timer count, which is ungated
    always_comb
    begin
        nxt_mosi_in   = p1_sync[`IOPM_BIT_MOSI] || !spi_en || spi_master; // R08
        nxt_sck_in    = p1_sync[`IOPM_BIT_SCK] || !spi_en || spi_master; // R09
        nxt_miso_in   = p1_sync[`IOPM_BIT_MISO] || !spi_en || !spi_master; // R13
        nxt_ss_n      = p1_sync[`IOPM_BIT_SS] || !spi_en; // R14
        nxt_ext_rst_n = p1_sync[`IOPM_BIT_RST] || !reset_fuse_enable; // R10
        nxt_dbg_clk   = p1_sync[`IOPM_BIT_RST] && onchip_debug_enable; // R11
        nxt_t0_in     = p3_sync[`IOPM_BIT_T0]; // R12
        nxt_gp_irq    = p1_sync & irq_en_ff; // R06 R07
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mosi_in_ff   <= 1'b1;
            sck_in_ff    <= 1'b1;
            miso_in_ff   <= 1'b1;
            ss_n_ff      <= 1'b1;
            ext_rst_n_ff <= 1'b1;
            dbg_clk_ff   <= 1'b0;
            t0_in_ff     <= 1'b1;
            gp_irq_ff    <= '0;
        end
        else
        begin
            mosi_in_ff   <= nxt_mosi_in;
            sck_in_ff    <= nxt_sck_in;
            miso_in_ff   <= nxt_miso_in;
            ss_n_ff      <= nxt_ss_n;
            ext_rst_n_ff <= nxt_ext_rst_n;
            dbg_clk_ff   <= nxt_dbg_clk;
            t0_in_ff     <= nxt_t0_in;
            gp_irq_ff    <= nxt_gp_irq;
        end
    end

    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;
    assign spi_mosi_in        = mosi_in_ff;
    assign spi_sck_in         = sck_in_ff;
    assign spi_miso_in        = miso_in_ff;
    assign spi_ss_n           = ss_n_ff;
    assign ext_reset_n        = ext_rst_n_ff;
    assign debug_serial_clock = dbg_clk_ff;
    assign timer0_count_in    = t0_in_ff;
    assign gp_irq_in          = gp_irq_ff;

endmodule

// ### tb/iopm_assertions.sv
// Checker: pad drive modes, pin functions and input paths.
// Bound to iopm_top; shadows APB register writes.
`timescale 1ns/1ps

module iopm_assertions
    import iopm_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [7:0]  port1_pin_in,
    input wire logic [7:0]  port1_pad_out,
    input wire logic [7:0]  port1_pad_oe,
    input wire logic [7:0]  port1_pad_pullup,
    input wire logic [7:0]  port3_pin_in,
    input wire logic        reset_fuse_enable,
    input wire logic        onchip_debug_enable,
    input wire logic        spi_mosi_out,
    input wire logic        spi_mosi_in,
    input wire logic        spi_sck_in,
    input wire logic        spi_miso_in,
    input wire logic        spi_ss_n,
    input wire logic        ext_reset_n,
    input wire logic        debug_serial_clock,
    input wire logic        timer0_count_in,
    input wire logic [7:0]  gp_irq_in
);
    logic [15:0] m_ff;
    logic [7:0]  o_ff;
    logic [7:0]  e_ff;
    logic [2:0]  a_ff;
    logic [2:0]  age_ff;
    wire         wr  = psel && penable && pready && pwrite;
    wire         ok  = age_ff == 3'h7;
    wire         slv = a_ff[0] && !a_ff[1];
    wire         mst = a_ff[0] && a_ff[1];

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Register shadow; age masks checks after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            m_ff   <= 16'h0000;
            o_ff   <= 8'hff;
            e_ff   <= 8'h00;
            a_ff   <= 3'h0;
            age_ff <= 3'h0;
        end
        else
        begin
            if (!ok)
                age_ff <= age_ff + 3'h1;
            if (wr && paddr == 8'h00)
                o_ff <= pwdata[7:0];
            if (wr && paddr == 8'h04)
                m_ff <= pwdata[15:0];
            if (wr && paddr == 8'h18)
                e_ff <= pwdata[7:0];
            if (wr && paddr == 8'h1c)
                a_ff <= pwdata[2:0];
        end
    end

    quasi_pin_a: assert property (
        ok && $past(m_ff[1:0]) == 2'h0 && $past(m_ff[1:0], 2) == 2'h0
        && $past(o_ff[0]) == $past(o_ff[0], 2) |-> port1_pad_pullup[0] == $past(o_ff[0])
        && port1_pad_oe[0] != $past(o_ff[0]) && !(port1_pad_oe[0] && port1_pad_out[0]))
        else $error("quasi pin level wrong");
    push_pin_a: assert property (
        ok && $past(m_ff[3:2]) == 2'h1 |-> port1_pad_oe[1] && !port1_pad_pullup[1]
        && port1_pad_out[1] == $past(o_ff[1]))
        else $error("push-pull pin wrong");
    input_float_a: assert property (
        ok && $past(m_ff[5:4]) == 2'h2 |-> !port1_pad_oe[2] && !port1_pad_pullup[2])
        else $error("input pin driven");
    open_drain_a: assert property (
        ok && $past(m_ff[7:6]) == 2'h3 && !$past(reset_fuse_enable | onchip_debug_enable)
        |-> port1_pad_oe[3] != $past(o_ff[3])
        && !port1_pad_pullup[3] && !(port1_pad_oe[3] && port1_pad_out[3]))
        else $error("open-drain pin wrong");
    irq_map_a: assert property (
        ok |-> gp_irq_in == ($past(port1_pin_in, 3) & $past(e_ff)))
        else $error("interrupt input wrong");
    fuse_reset_a: assert property (
        ok |-> ext_reset_n == (!$past(reset_fuse_enable) | $past(port1_pin_in[3], 3)))
        else $error("external reset wrong");
    debug_clock_a: assert property (
        ok |-> debug_serial_clock == ($past(onchip_debug_enable) & $past(port1_pin_in[3], 3)))
        else $error("debug clock wrong");
    timer_count_a: assert property (
        ok |-> timer0_count_in == $past(port3_pin_in[4], 3))
        else $error("timer count input wrong");
    slave_in_a: assert property (
        ok |-> spi_mosi_in == (!$past(slv) | $past(port1_pin_in[5], 3))
        && spi_sck_in == (!$past(slv) | $past(port1_pin_in[7], 3)))
        else $error("slave inputs wrong");
    master_in_a: assert property (
        ok |-> spi_miso_in == (!$past(mst) | $past(port1_pin_in[6], 3))
        && spi_ss_n == (!$past(a_ff[0]) | $past(port1_pin_in[4], 3)))
        else $error("master input or select wrong");
    alt_out_a: assert property (
        ok && $past(mst) && $past(m_ff[11:10]) == 2'h1
        |-> port1_pad_oe[5] && port1_pad_out[5] == $past(spi_mosi_out))
        else $error("master output not on pad");

    slave_c: cover property (ok && slv);
    master_c: cover property (ok && mst);
    fuse_c: cover property (ok && reset_fuse_enable && !ext_reset_n);
endmodule

bind iopm_top iopm_assertions chk_u (.*);

// ### tb/iopm_board.sv
// Board model of one port: pad, weak pull-up or external driver.
// A pin nobody drives toggles each cycle.
`timescale 1ns/1ps

module iopm_board
(
    input  wire logic       pclk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin
);
    logic [7:0] float_ff = 8'h55;
    always_ff @(posedge pclk)
        float_ff <= ~float_ff;
    assign pin = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
               | (~pad_oe & ~ext_en & (pad_pullup | float_ff));
endmodule

// ### tb/iopm_tb_top.sv
// Testbench: APB access, pad drive modes, pin functions.
// Assumes two board models and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module iopm_tb_top;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic [7:0]  p1_in, p1_out, p1_oe, p1_pu, p3_in, p3_out, p3_oe, p3_pu, irq;
    logic [7:0]  p1_en = 8'h00, p1_val = 8'h00, p3_en = 8'h00, p3_val = 8'h00;
    logic        fuse = 1'b0, dbg = 1'b0, mosi_o = 1'b0, sck_o = 1'b0;
    logic        miso_o = 1'b0, pwm_o = 1'b0, s, m;
    logic        mosi_i, sck_i, miso_i, ss_n, rst_n, dclk, t0_i, err_q, pready, pslverr;
    logic [15:0] mw [2] = '{16'h00e4, 16'he400};
    int          error_cnt = 0;
    int          samples_checked = 0;

    always #5 pclk = ~pclk;

    iopm_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port1_pin_in(p1_in), .port1_pad_out(p1_out),
        .port1_pad_oe(p1_oe), .port1_pad_pullup(p1_pu), .port3_pin_in(p3_in),
        .port3_pad_out(p3_out), .port3_pad_oe(p3_oe), .port3_pad_pullup(p3_pu),
        .reset_fuse_enable(fuse), .onchip_debug_enable(dbg), .spi_mosi_out(mosi_o),
        .spi_sck_out(sck_o), .spi_miso_out(miso_o), .timer0_pwm_out(pwm_o),
        .spi_mosi_in(mosi_i), .spi_sck_in(sck_i), .spi_miso_in(miso_i), .spi_ss_n(ss_n),
        .ext_reset_n(rst_n), .debug_serial_clock(dclk), .timer0_count_in(t0_i),
        .gp_irq_in(irq));
    iopm_board brd1_u (.pclk, .pad_out(p1_out), .pad_oe(p1_oe),
        .pad_pullup(p1_pu), .ext_en(p1_en), .ext_val(p1_val), .pin(p1_in));
    iopm_board brd3_u (.pclk, .pad_out(p3_out), .pad_oe(p3_oe),
        .pad_pullup(p3_pu), .ext_en(p3_en), .ext_val(p3_val), .pin(p3_in));

    task automatic report_and_stop();
        $display("checks %0d bad %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1 && ++n < 16);
        if (pready !== 1'b1)
        begin
            error_cnt++;
            report_and_stop();
        end
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic x);
        xfer(1'b0, a, 32'h0);
        `CHK("prdata", e, rd_q)
        `CHK("pslverr", x, err_q)
    endtask

    task automatic settle();
        repeat (5) @(negedge pclk);
    endtask

    // Expected {oe, out, pull-up} of a pin
    function automatic logic [2:0] pad_exp(input logic [1:0] md, input logic d);
        case (md)
            2'h0: pad_exp = d ? 3'b001 : 3'b100;
            2'h1: pad_exp = {1'b1, d, 1'b0};
            2'h2: pad_exp = 3'b000;
            default: pad_exp = d ? 3'b000 : 3'b100;
        endcase
    endfunction

    task automatic chk_pads(input logic [15:0] md, input logic [7:0] d);
        logic [2:0] e;
        settle();
        for (int i = 0; i < 8; i++)
        begin
            e = pad_exp(md[2*i +: 2], d[i]);
            `CHK("p1 pad", e, {p1_oe[i], p1_out[i] & p1_oe[i], p1_pu[i]})
            `CHK("p3 pad", e, {p3_oe[i], p3_out[i] & p3_oe[i], p3_pu[i]})
        end
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'hff, 1'b0);
        rd(8'h04, 32'h0, 1'b0);
        rd(8'h1c, 32'h0, 1'b0);
        chk_pads(16'h0000, 8'hff);
        wr(8'h20, 32'h1);
        rd(8'h20, 32'h0, 1'b1);
        $display("reset done");
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h04, {16'h0, mw[k % 2]});
            wr(8'h0c, {16'h0, mw[k % 2]});
            wr(8'h00, k < 2 ? 32'h5a : 32'ha5);
            wr(8'h08, k < 2 ? 32'h5a : 32'ha5);
            chk_pads(mw[k % 2], k < 2 ? 8'h5a : 8'ha5);
        end
        $display("modes done");
        wr(8'h04, 32'haaaa);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            p1_en  <= 8'hff;
            p1_val <= 8'h01 << i;
            wr(8'h18, 32'hff);
            settle();
            `CHK("irq", 8'h01 << i, irq)
            rd(8'h10, 32'h01 << i, 1'b0);
            wr(8'h18, {24'h0, ~(8'h01 << i)});
            settle();
            `CHK("irq masked", 8'h00, irq)
        end
        $display("interrupts done");
        wr(8'h04, 32'h0);
        wr(8'h00, 32'hff);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge pclk);
            fuse   <= k[0];
            dbg    <= k[1];
            p1_val <= {4'h0, k[2], 3'h0};
            settle();
            `CHK("ext reset", k[0] ? k[2] : 1'b1, rst_n)
            `CHK("dbg clock", k[1] & k[2], dclk)
            `CHK("bit3 pullup", !(k[0] | k[1]), p1_pu[3])
        end
        @(posedge pclk);
        fuse   <= 1'b0;
        dbg    <= 1'b0;
        $display("reset pin done");
        wr(8'h04, 32'h5400);
        for (int r = 0; r < 3; r++)
        begin
            s = r == 1;
            m = r == 2;
            wr(8'h1c, {30'h0, m, r != 0});
            settle();
            `CHK("mosi in", !s, mosi_i)
            `CHK("sck in", !s, sck_i)
            `CHK("miso in", !m, miso_i)
            `CHK("ss", r == 0, ss_n)
            `CHK("p1 oe", {!s, !m, !s}, p1_oe[7:5])
            `CHK("p1 out", {3{r == 0}}, p1_out[7:5] & p1_oe[7:5])
        end
        $display("spi done");
        wr(8'h0c, 32'h0100);
        wr(8'h08, 32'h0);
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h1c, {29'h0, k[0], 2'b00});
            @(posedge pclk);
            pwm_o <= k[1];
            settle();
            `CHK("t0 pad", k[0] & k[1], p3_out[4] & p3_oe[4])
            `CHK("t0 count", k[0] & k[1], t0_i)
        end
        wr(8'h0c, 32'h0200);
        @(posedge pclk);
        p3_en  <= 8'hff;
        p3_val <= 8'h10;
        settle();
        `CHK("t0 count ext", 1'b1, t0_i)
        $display("timer done");
        report_and_stop();
    end
endmodule
